// File: rtl/selfprog_map.vh
`ifndef SELFPROG_MAP_VH
`define SELFPROG_MAP_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OFS_CTRL 8'h00
`define OFS_POINTER 8'h04
`define OFS_DATA 8'h08
`define OFS_INSTR 8'h0C
`define OFS_RESULT 8'h10
`define OFS_BUFMASK 8'h14
`define OFS_STATUS 8'h18

// ****************************************************************
// Control register fields
// ****************************************************************
`define CTL_IRQ_EN 7
`define CTL_CBUSY 6
`define CTL_CREAD_EN 4
`define CTL_LOCK_SET 3
`define CTL_PAGE_WR 2
`define CTL_PAGE_ERS 1
`define CTL_SP_EN 0
`define CTL_RESET 8'h00

// Lower five-bit commands
`define CMD_CREAD 5'b1_0001
`define CMD_LOCK 5'b0_1001
`define CMD_WRITE 5'b0_0101
`define CMD_ERASE 5'b0_0011
`define CMD_LOAD 5'b0_0001

// ****************************************************************
// Pointer fields and readback selectors
// ****************************************************************
`define PTR_PAGE_HI 12
`define PTR_PAGE_LO 6
`define PTR_WORD_HI 5
`define PTR_WORD_LO 1
`define SEL_FUSE_LOW 16'h0000
`define SEL_LOCK 16'h0001
`define SEL_FUSE_EXT 16'h0002
`define SEL_FUSE_HIGH 16'h0003

// Lock bits 5..2 boot locks, 1..0 memory locks
`define LOCK_BOOT_HI 5
`define LOCK_BOOT_LO 2
`define LOCK_RESET 8'hFF

// ****************************************************************
// Timing
// ****************************************************************
`define STORE_WINDOW 3'd4
`define LOAD_WINDOW 3'd3
`define CLK_PERIOD_PS 8000
`define PROG_TIME_US 4500
// Scaled so that the intermediate product stays inside 32 bits
`define PROG_CYCLES ((`PROG_TIME_US * 1000) / (`CLK_PERIOD_PS / 1000))

`endif

// File: rtl/prog_timer.v
`timescale 1ns/1ps
`default_nettype none
`include "selfprog_map.vh"

// ****************************************************************
// Flash operation timer
// ****************************************************************
module prog_timer #(
   parameter integer CYCLES = `PROG_CYCLES
) (
   input wire ref_clk,
   input wire reset_n,
   input wire start,
   output reg running_q,
   output reg done_q
);

   reg [31:0] count_q;

   // Reset does not stop a running operation: the cell must finish
   // Reset sits in the else branch so an unknown flag still gets cleared
   always @(posedge ref_clk) begin
      if (reset_n || running_q) begin
         done_q <= 1'b0;
         if (running_q) begin
            if (count_q == CYCLES - 1) begin
               running_q <= 1'b0;
               done_q <= 1'b1;
               count_q <= 32'h0000_0000;
            end else begin
               count_q <= count_q + 32'h0000_0001;
            end
         end else if (start) begin
            running_q <= 1'b1;
            count_q <= 32'h0000_0000;
         end
      end else begin
         count_q <= 32'h0000_0000;
         running_q <= 1'b0;
         done_q <= 1'b0;
      end
   end

endmodule // prog_timer

`default_nettype wire

// File: rtl/flash_self_program_sequencer.v
// Functional notes
// - Erase: command 00011, store within four cycles
// - Erase uses only page field of pointer
// - Concurrent target runs on; halting target stalls
// - Load: command 00001 stores data at word
// - Buffer clears on write, read-enable, reset
// - EEPROM write during loading discards buffer
// - Write: command 00101, data ignored, page only
// - Ready interrupt while enable bit clear
// - Erase/write of a concurrent page blocks reads, busy flag
// - Lock set: command 01001, value from data zero
// - Zero bits 5..2 program boot locks
// - Lock programming never stalls or blocks reads
// - EEPROM busy rejects programming and readback
// - Pointer 0001 readback returns lock byte
// - Lock-set, enable self-clear on end/timeout
// - Lock byte layout 5..2 boot, 1..0 memory
// - Pointers 0000, 0002, 0003 select fuse bytes
// - Programmed bits read zero, unprogrammed one
// - Reset never aborts a running flash write
// - Control register bit layout
// - Unlisted five-bit commands have no effect
// - Enable bit stays set until operation ends
// - Page load clears concurrent busy flag
`timescale 1ns/1ps
`default_nettype none
`include "selfprog_map.vh"

module flash_self_program_sequencer #(
   parameter integer PROG_CYCLES = `PROG_CYCLES,
   parameter integer HALT_PAGE_FIRST = 96,
   parameter integer PAGE_WORDS = 32
) (
   input wire ref_clk,
   input wire reset_n,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire hready,
   input wire [31:0] hwdata,
   output reg [31:0] hrdata,
   output reg hreadyout,
   output reg hresp,
   input wire eeprom_write_busy,
   input wire [7:0] fuse_low_byte,
   input wire [7:0] fuse_high_byte,
   input wire [7:0] extended_fuse_byte,
   output reg core_halt_q,
   output reg concurrent_read_block_q,
   output reg ready_irq_q,
   output reg flash_erase_q,
   output reg flash_write_q,
   output reg flash_lock_q,
   output reg [6:0] flash_page_q
);

   // ****************************************************************
   // State
   // ****************************************************************
   reg [7:0] ctrl_q;
   reg [15:0] pointer_q;
   reg [7:0] data_reg_zero_q;
   reg [7:0] data_reg_one_q;
   reg [7:0] result_q;
   reg [7:0] lock_q;
   reg [7:0] lock_value_q;
   reg [2:0] window_q;
   reg [1:0] op_q;
   reg [PAGE_WORDS-1:0] buf_valid_q;
   reg [15:0] page_buf [0:PAGE_WORDS-1];
   reg wr_pend_q;
   reg [7:0] wr_addr_q;
   reg eeprom_busy_prev_q;
   wire timer_running;
   wire timer_done;
   reg timer_start;

   localparam [1:0] OP_NONE = 2'd0;
   localparam [1:0] OP_ERASE = 2'd1;
   localparam [1:0] OP_WRITE = 2'd2;
   localparam [1:0] OP_LOCK = 2'd3;

   wire busy = timer_running | (op_q != OP_NONE);
   wire [4:0] word_sel = pointer_q[`PTR_WORD_HI:`PTR_WORD_LO];
   wire [6:0] page_sel = pointer_q[`PTR_PAGE_HI:`PTR_PAGE_LO];

   // ****************************************************************
   // Bus decode
   // ****************************************************************
   function is_reg;
      input [7:0] a;
      input [7:0] ofs;
      begin
         is_reg = (a == ofs);
      end
   endfunction

   wire addr_phase = hsel & hready & htrans[1];
   wire wr_now = wr_pend_q;
   wire [4:0] cmd_in = hwdata[4:0];
   wire ctrl_wr = wr_now && is_reg(wr_addr_q, `OFS_CTRL);
   wire instr_wr = wr_now && is_reg(wr_addr_q, `OFS_INSTR);
   wire store_ins = instr_wr & hwdata[0];
   wire load_ins = instr_wr & hwdata[1] & ~hwdata[0];
   wire cmd_ok = (cmd_in == `CMD_CREAD) || (cmd_in == `CMD_LOCK) ||
                 (cmd_in == `CMD_WRITE) || (cmd_in == `CMD_ERASE) ||
                 (cmd_in == `CMD_LOAD);
   wire store_open = ctrl_q[`CTL_SP_EN] && (window_q != 3'd0) &&
                     (op_q == OP_NONE);
   wire load_open = store_open && ctrl_q[`CTL_LOCK_SET] &&
                    (window_q > `STORE_WINDOW - `LOAD_WINDOW);

   // Accepted requests; an EEPROM write refuses both
   wire store_go = store_ins && store_open && !eeprom_write_busy;
   wire load_go = load_ins && load_open && !eeprom_write_busy;

   // Registered answer: data in the data phase, zero wait states
   always @(posedge ref_clk) begin
      if (!reset_n) begin
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b0;
         hresp <= 1'b0;
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         wr_pend_q <= addr_phase & hwrite;
         wr_addr_q <= {haddr[7:2], 2'b00};
         if (addr_phase && !hwrite) begin
            if (is_reg(haddr[7:0], `OFS_CTRL)) begin
               hrdata <= {24'h00_0000, ctrl_q[7:6], 1'b0, ctrl_q[4:0]};
            end else if (is_reg(haddr[7:0], `OFS_POINTER)) begin
               hrdata <= {16'h0000, pointer_q};
            end else if (is_reg(haddr[7:0], `OFS_DATA)) begin
               // Upper half shows the buffer word that the pointer selects
               hrdata <= {(buf_valid_q[word_sel] ? page_buf[word_sel] :
                          16'h0000), data_reg_one_q, data_reg_zero_q};
            end else if (is_reg(haddr[7:0], `OFS_RESULT)) begin
               hrdata <= {24'h00_0000, result_q};
            end else if (is_reg(haddr[7:0], `OFS_BUFMASK)) begin
               hrdata <= {{(32-PAGE_WORDS){1'b0}}, buf_valid_q};
            end else if (is_reg(haddr[7:0], `OFS_STATUS)) begin
               hrdata <= {29'h0000_0000, eeprom_write_busy, core_halt_q,
                          busy};
            end else begin
               hrdata <= 32'h0000_0000;
            end
         end
      end
   end

   // ****************************************************************
   // Readback selection
   // ****************************************************************
   // Fuse and lock cells read zero when programmed
   function [7:0] readback;
      input [15:0] ptr;
      input [7:0] lockb;
      input [7:0] flo;
      input [7:0] fhi;
      input [7:0] fex;
      begin
         if (ptr == `SEL_LOCK) begin
            readback = {2'b11, lockb[5:0]};
         end else if (ptr == `SEL_FUSE_EXT) begin
            readback = fex;
         end else if (ptr == `SEL_FUSE_HIGH) begin
            readback = fhi;
         end else begin
            readback = flo;
         end
      end
   endfunction

   // ****************************************************************
   // Sequencer
   // ****************************************************************
   always @* begin
      timer_start = 1'b0;
      if (store_go) begin
         if (ctrl_q[4:0] == `CMD_ERASE || ctrl_q[4:0] == `CMD_WRITE ||
             ctrl_q[4:0] == `CMD_LOCK) begin
            timer_start = 1'b1;
         end
      end
   end

   // Reset is held off while a flash cell operation runs; only the timer
   // gates it, so an unknown op code at power-up cannot hold reset off
   always @(posedge ref_clk) begin
      if (!reset_n && !timer_running) begin
         ctrl_q <= `CTL_RESET;
         pointer_q <= 16'h0000;
         data_reg_zero_q <= 8'h00;
         data_reg_one_q <= 8'h00;
         result_q <= 8'h00;
         window_q <= 3'd0;
         op_q <= OP_NONE;
         buf_valid_q <= {PAGE_WORDS{1'b0}};
         eeprom_busy_prev_q <= 1'b0;
         core_halt_q <= 1'b0;
         concurrent_read_block_q <= 1'b0;
         ready_irq_q <= 1'b0;
         flash_erase_q <= 1'b0;
         flash_write_q <= 1'b0;
         flash_lock_q <= 1'b0;
         flash_page_q <= 7'h00;
         lock_value_q <= 8'hFF;
      end else if (reset_n) begin
         eeprom_busy_prev_q <= eeprom_write_busy;
         ready_irq_q <= ctrl_q[`CTL_IRQ_EN] & ~ctrl_q[`CTL_SP_EN];
         concurrent_read_block_q <= ctrl_q[`CTL_CBUSY];

         // Software register writes
         if (wr_now && is_reg(wr_addr_q, `OFS_POINTER)) begin
            pointer_q <= hwdata[15:0];
         end
         if (wr_now && is_reg(wr_addr_q, `OFS_DATA)) begin
            data_reg_zero_q <= hwdata[7:0];
            data_reg_one_q <= hwdata[15:8];
         end

         // Window countdown; lapse drops the pending command
         if (window_q != 3'd0 && op_q == OP_NONE) begin
            window_q <= window_q - 3'd1;
            if (window_q == 3'd1) begin
               ctrl_q[4:0] <= 5'b0_0000;
            end
         end

         // EEPROM write while buffer holds data loses it all
         if (eeprom_write_busy && !eeprom_busy_prev_q) begin
            buf_valid_q <= {PAGE_WORDS{1'b0}};
         end

         if (ctrl_wr && !busy) begin
            ctrl_q[`CTL_IRQ_EN] <= hwdata[`CTL_IRQ_EN];
            if (cmd_ok && !eeprom_write_busy) begin
               ctrl_q[4:0] <= cmd_in;
               window_q <= `STORE_WINDOW;
            end
         end else if (store_go) begin
            window_q <= 3'd0;
            case (ctrl_q[4:0])
               `CMD_LOAD: begin
                  page_buf[word_sel] <= {data_reg_one_q,
                                         data_reg_zero_q};
                  buf_valid_q[word_sel] <= 1'b1;
                  ctrl_q[`CTL_CBUSY] <= 1'b0;
                  ctrl_q[4:0] <= 5'b0_0000;
               end
               `CMD_CREAD: begin
                  ctrl_q[`CTL_CBUSY] <= 1'b0;
                  buf_valid_q <= {PAGE_WORDS{1'b0}};
                  ctrl_q[4:0] <= 5'b0_0000;
               end
               `CMD_ERASE, `CMD_WRITE: begin
                  // Only the page field is taken; data ignored
                  flash_page_q <= page_sel;
                  // A store in the last window cycle keeps the command
                  ctrl_q[4:0] <= ctrl_q[4:0];
                  if (ctrl_q[`CTL_PAGE_ERS]) begin
                     op_q <= OP_ERASE;
                     flash_erase_q <= 1'b1;
                  end else begin
                     op_q <= OP_WRITE;
                     flash_write_q <= 1'b1;
                  end
                  if (page_sel >= HALT_PAGE_FIRST) begin
                     core_halt_q <= 1'b1;
                  end else begin
                     ctrl_q[`CTL_CBUSY] <= 1'b1;
                     concurrent_read_block_q <= 1'b1;
                  end
               end
               default: begin
                  // Lock set; pointer is a don't care, no stall
                  op_q <= OP_LOCK;
                  flash_lock_q <= 1'b1;
                  lock_value_q <= data_reg_zero_q;
                  ctrl_q[4:0] <= ctrl_q[4:0];
               end
            endcase
         end else if (load_go) begin
            result_q <= readback(pointer_q, lock_q, fuse_low_byte,
                                 fuse_high_byte, extended_fuse_byte);
            ctrl_q[4:0] <= 5'b0_0000;
            window_q <= 3'd0;
         end

         // Enable bit stays high until the cell operation ends
         if (timer_done) begin
            ctrl_q[4:0] <= 5'b0_0000;
            op_q <= OP_NONE;
            core_halt_q <= 1'b0;
            flash_erase_q <= 1'b0;
            flash_write_q <= 1'b0;
            flash_lock_q <= 1'b0;
            if (op_q == OP_WRITE) begin
               buf_valid_q <= {PAGE_WORDS{1'b0}};
            end
         end
      end
   end

   // ****************************************************************
   // Non-volatile lock cells
   // ****************************************************************
   // Lock cells hold through reset; no path sets a programmed lock bit back to one
   initial lock_q = `LOCK_RESET;
   always @(posedge ref_clk) begin
      if (timer_done && op_q == OP_LOCK) begin
         lock_q[`LOCK_BOOT_HI:`LOCK_BOOT_LO] <=
            lock_q[`LOCK_BOOT_HI:`LOCK_BOOT_LO] &
            lock_value_q[`LOCK_BOOT_HI:`LOCK_BOOT_LO];
      end
   end

   prog_timer #(
      .CYCLES(PROG_CYCLES)
   ) u_timer (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .start(timer_start),
      .running_q(timer_running),
      .done_q(timer_done)
   );

endmodule // flash_self_program_sequencer

`default_nettype wire

// File: dv/selfprog_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************
// Port checker
// ****************************************************
module selfprog_monitor #(
   parameter integer PROG_CYCLES = 20
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic eeprom_write_busy,
   input wire logic core_halt_q,
   input wire logic concurrent_read_block_q,
   input wire logic ready_irq_q,
   input wire logic flash_erase_q,
   input wire logic flash_write_q,
   input wire logic flash_lock_q,
   input wire logic [6:0] flash_page_q
);
   wire ew = flash_erase_q | flash_write_q;
   wire op_any = ew | flash_lock_q;
   // Not cleared by reset: a reset never aborts an operation
   logic [31:0] op_cnt_q;
   always @(posedge ref_clk) begin
      if (op_any)
         op_cnt_q <= op_cnt_q + 32'h0000_0001;
      else
         op_cnt_q <= 32'h0000_0000;
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   chk_halt_cause: assert property (core_halt_q |-> ew || $past(ew))
      else $error("halt without erase or write");
   chk_lock_nohalt: assert property (flash_lock_q |-> !core_halt_q)
      else $error("halt during lock setting");
   chk_irq_quiet: assert property (ew && $past(ew) |-> !ready_irq_q)
      else $error("ready irq while operation runs");
   chk_block_set: assert property ($rose(ew) && !core_halt_q
      |-> ##[0:2] concurrent_read_block_q)
      else $error("concurrent reads not blocked");
   chk_op_length: assert property ($fell(op_any)
      |-> op_cnt_q + 2 >= PROG_CYCLES && op_cnt_q <= PROG_CYCLES + 2)
      else $error("operation length wrong");
   chk_single_op: assert property (
      $onehot0({flash_erase_q, flash_write_q, flash_lock_q}))
      else $error("two operations at once");
   chk_page_stable: assert property (ew && $past(ew)
      |-> $stable(flash_page_q))
      else $error("page changed during operation");
   chk_eeprom_block: assert property (eeprom_write_busy[*7]
      |-> !$rose(op_any))
      else $error("operation started while eeprom busy");
   cover property ($rose(flash_erase_q) && !core_halt_q);
   cover property ($rose(core_halt_q));
   cover property ($rose(flash_lock_q));
endmodule // selfprog_monitor
bind flash_self_program_sequencer selfprog_monitor #(
   .PROG_CYCLES(PROG_CYCLES)) i_mon (.ref_clk(ref_clk), .reset_n(reset_n),
   .eeprom_write_busy(eeprom_write_busy), .core_halt_q(core_halt_q),
   .concurrent_read_block_q(concurrent_read_block_q),
   .ready_irq_q(ready_irq_q), .flash_erase_q(flash_erase_q),
   .flash_write_q(flash_write_q), .flash_lock_q(flash_lock_q),
   .flash_page_q(flash_page_q));
`default_nettype wire

// File: dv/core_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "selfprog_map.vh"
// ****************************************************
// Core model: bus master and timed sequences
// ****************************************************
module core_bus_model (
   input wire logic ref_clk,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   output logic hsel,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata
);
   initial begin
      hsel = 1'b1;
      haddr = 32'h0000_0000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0000_0000;
   end
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
      haddr <= {24'h00_0000, a};
      htrans <= 2'b10;
      hwrite <= w;
      do @(posedge ref_clk); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge ref_clk); while (hready !== 1'b1);
      q = hrdata;
      // Released data must not look valid
      hwdata <= ~d;
   endtask
   // Back to back keeps the instruction inside the window
   task seq(input logic [7:0] ctl, input logic [31:0] ins);
      logic [31:0] q;
      xfer(1'b1, `OFS_CTRL, {24'h00_0000, ctl}, q);
      xfer(1'b1, `OFS_INSTR, ins, q);
   endtask
endmodule // core_bus_model
`default_nettype wire

// File: dv/tb_flash_self_program_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "selfprog_map.vh"
// ****************************************************
// Bench
// ****************************************************
module tb_flash_self_program_sequencer;
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   logic ee = 1'b0;
   logic [7:0] f_lo = 8'h00, f_hi = 8'h00, f_ex = 8'h00;
   wire [31:0] haddr, hwdata, hrdata;
   wire [1:0] htrans;
   wire [2:0] hsize;
   wire [6:0] page_q;
   wire hsel, hwrite, hrdy, hresp, halt_q, blk_q, irq_q, ers_q, wrt_q, lck_q;
   int n_mismatch = 0, checks_done = 0, exp_mask = 0, exp_lock = 8'hff;
   logic [31:0] q;
   always #4 ref_clk = ~ref_clk;
   flash_self_program_sequencer #(.PROG_CYCLES(20)) i_dut (
      .ref_clk(ref_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hrdy),
      .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hrdy), .hresp(hresp),
      .eeprom_write_busy(ee), .fuse_low_byte(f_lo), .fuse_high_byte(f_hi),
      .extended_fuse_byte(f_ex), .core_halt_q(halt_q),
      .concurrent_read_block_q(blk_q), .ready_irq_q(irq_q),
      .flash_erase_q(ers_q), .flash_write_q(wrt_q), .flash_lock_q(lck_q),
      .flash_page_q(page_q));
   core_bus_model i_core (.ref_clk(ref_clk), .hready(hrdy),
      .hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
   task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         n_mismatch++;
         $display("[ERR] %s exp %h seen %h", nm, e, s);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      i_core.xfer(1'b1, a, d, q);
   endtask
   task rd(input logic [7:0] a);
      i_core.xfer(1'b0, a, 32'h0000_0000, q);
   endtask
   task cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task wait_op;
      int n;
      n = 0;
      while ((ers_q | wrt_q | lck_q) !== 1'b0 && n < 100) begin
         cyc(1);
         n++;
      end
      chk("op end", n < 100, 1);
      cyc(1);
   endtask
   task load_word(input int w);
      int d;
      d = $urandom;
      wr(`OFS_POINTER, w << 1);
      wr(`OFS_DATA, d);
      i_core.seq(`CMD_LOAD, 1);
      exp_mask |= 1 << w;
      rd(`OFS_BUFMASK);
      chk("mask", q, exp_mask);
      rd(`OFS_DATA);
      chk("word", q, {d[15:0], d[15:0]});
   endtask
   task tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      #100000;
      n_mismatch++;
      tally_and_finish;
   end
   initial begin
      int w, v, sel[3];
      sel = '{0, 2, 3};
      w = $urandom(44);
      repeat (10) @(posedge ref_clk);
      reset_n <= 1'b1;
      cyc(1);
      rd(`OFS_CTRL);
      chk("ctrl rst", q, 0);
      rd(`OFS_BUFMASK);
      chk("mask rst", q, 0);
      rd(8'h40);
      chk("unmapped", q, 0);
      chk("resp", hresp, 0);
      for (int i = 0; i < 4; i++) begin
         do v = $urandom % 32; while (v inside {17, 9, 5, 3, 1});
         i_core.seq(v, 1);
         cyc(2);
         chk("ops", {ers_q, wrt_q, lck_q}, 0);
         rd(`OFS_CTRL);
         chk("ctrl bad", q, 0);
      end
      $display("test reset and commands done");
      v = $urandom % 96;
      wr(`OFS_POINTER, 32'h0000_e03f | (v << 6));
      wr(`OFS_DATA, $urandom);
      i_core.seq(`CMD_ERASE, 1);
      cyc(3);
      chk("erase", ers_q, 1);
      chk("page", page_q, v);
      chk("halt", halt_q, 0);
      chk("block", blk_q, 1);
      rd(`OFS_CTRL);
      chk("ctrl run", q & 8'h41, 8'h41);
      wait_op;
      rd(`OFS_CTRL);
      chk("ctrl end", q & 8'h41, 8'h40);
      w = $urandom % 32;
      // Distinct words only between clears
      for (int k = 0; k < 2; k++)
         load_word((w + k) % 32);
      rd(`OFS_CTRL);
      chk("busy clr", q & 8'h40, 0);
      i_core.seq(`CMD_CREAD, 1);
      exp_mask = 0;
      rd(`OFS_BUFMASK);
      chk("mask cread", q, exp_mask);
      $display("test erase and load done");
      load_word(w);
      wr(`OFS_POINTER, (96 + $urandom % 32) << 6);
      i_core.seq(`CMD_WRITE, 1);
      cyc(3);
      chk("write", wrt_q, 1);
      chk("halt wr", halt_q, 1);
      wait_op;
      exp_mask = 0;
      rd(`OFS_BUFMASK);
      chk("mask wr", q, exp_mask);
      chk("halt off", halt_q, 0);
      v = 8'hc3 | ($urandom & 8'h3c);
      exp_lock &= v;
      wr(`OFS_POINTER, 1);
      wr(`OFS_DATA, v);
      i_core.seq(`CMD_LOCK, 1);
      cyc(3);
      chk("lock", lck_q, 1);
      chk("lock halt", {halt_q, blk_q}, 0);
      wait_op;
      i_core.seq(`CMD_LOCK, 2);
      rd(`OFS_RESULT);
      chk("lock byte", q[7:0], exp_lock);
      rd(`OFS_CTRL);
      chk("ctrl lock", q & 8'h09, 0);
      @(posedge ref_clk);
      f_lo <= $urandom;
      f_hi <= $urandom;
      f_ex <= $urandom;
      cyc(1);
      for (int i = 0; i < 3; i++) begin
         wr(`OFS_POINTER, sel[i]);
         i_core.seq(`CMD_LOCK, 2);
         rd(`OFS_RESULT);
         chk("fuse", q[7:0], i == 0 ? f_lo : i == 1 ? f_ex : f_hi);
      end
      $display("test write and lock done");
      wr(`OFS_CTRL, `CMD_LOAD);
      cyc(6);
      wr(`OFS_INSTR, 1);
      rd(`OFS_CTRL);
      chk("lapse", q & 8'h01, 0);
      rd(`OFS_BUFMASK);
      chk("mask lapse", q, exp_mask);
      wr(`OFS_CTRL, 8'h81);
      cyc(1);
      chk("irq off", irq_q, 0);
      wr(`OFS_INSTR, 1);
      cyc(3);
      chk("irq on", irq_q, 1);
      @(posedge ref_clk);
      ee <= 1'b1;
      cyc(2);
      rd(`OFS_BUFMASK);
      chk("mask ee", q, 0);
      i_core.seq(`CMD_ERASE, 1);
      cyc(3);
      chk("ee erase", ers_q, 0);
      @(posedge ref_clk);
      ee <= 1'b0;
      cyc(1);
      wr(`OFS_POINTER, 0);
      i_core.seq(`CMD_ERASE, 1);
      cyc(3);
      @(posedge ref_clk);
      reset_n <= 1'b0;
      cyc(3);
      chk("rst erase", ers_q, 1);
      @(posedge ref_clk);
      reset_n <= 1'b1;
      wait_op;
      $display("test window eeprom reset done");
      tally_and_finish;
   end
endmodule // tb_flash_self_program_sequencer
`default_nettype wire
